// ==== design/flash_pkg.sv ====
// =====================================================================
// Shared constants of the serial flash status block
package flash_pkg;

	// Instruction codes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
	localparam logic [7:0] OP_WRITE_BYTE_ONE = 8'h01;
	localparam logic [7:0] OP_WRITE_BYTE_TWO = 8'h31;
	localparam logic [7:0] OP_WRITE_BYTE_THREE = 8'h11;
	localparam logic [7:0] OP_READ_BYTE_ONE = 8'h05;
	localparam logic [7:0] OP_READ_BYTE_TWO = 8'h35;
	localparam logic [7:0] OP_READ_BYTE_THREE = 8'h15;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;

	// Field masks of the three status bytes
	localparam logic [7:0] BUSY_MASK = 8'h01;
	localparam logic [7:0] LATCH_MASK = 8'h02;
	localparam logic [7:0] PAUSED_MASK = 8'h80;
	localparam logic [7:0] CFG_MASK_ONE = 8'hFC;
	localparam logic [7:0] CFG_MASK_TWO = 8'h43;
	localparam logic [7:0] LOCK_MASK_TWO = 8'h38;
	localparam logic [7:0] CFG_MASK_THREE = 8'hF0;
	localparam logic [7:0] PROT_UPPER_MASK = 8'h01;

	// Field positions
	localparam int B1_PROT_LOWER = 7;
	localparam int B1_RANGE_LSB = 2;
	localparam int B2_INVERT = 6;
	localparam int B2_LOCK_LSB = 3;
	localparam int B2_QUAD = 1;
	localparam int B2_PROT_UPPER = 0;
	localparam int B3_SHARED_PIN = 7;
	localparam int B3_DRIVE_LSB = 5;
	localparam int B3_FAST_QUAD = 4;

	// Factory values of the non-volatile bytes
	localparam logic [7:0] NV_ONE_RESET = 8'h00;
	localparam logic [7:0] NV_TWO_RESET = 8'h00;
	localparam logic [7:0] NV_THREE_RESET = 8'h00;

	// Protect modes, {upper, lower}
	localparam logic [1:0] PROT_SOFTWARE = 2'h0;
	localparam logic [1:0] PROT_PIN = 2'h1;
	localparam logic [1:0] PROT_LOCKDOWN = 2'h2;
	localparam logic [1:0] PROT_OTP = 2'h3;

	// Frame lengths in bits
	localparam int BYTE_BITS = 8;
	localparam int LEN_CMD = 8;
	localparam int LEN_ONE = 16;
	localparam int LEN_TWO = 24;
	localparam int LEN_ERASE = 32;
	localparam int LEN_PROGRAM_MIN = 40;

	// Timing
	localparam int REF_CLK_NS = 50;
	localparam int STATUS_WRITE_NS = 500;
	localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_NS + REF_CLK_NS - 1) / REF_CLK_NS;

	// Device sequencer states
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_STATUS_WRITE = 2'b01,
		DEV_ARRAY_OP = 2'b10
	} dev_state_t;

	// Host link states
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b000,
		HOST_RISE_WAIT = 3'b001,
		HOST_FALL_WAIT = 3'b010,
		HOST_TAIL = 3'b011,
		HOST_GAP = 3'b100
	} host_state_t;

endpackage

// ==== design/flash_link_if.sv ====
`timescale 1ns/1ps
// =====================================================================
// Serial flash link between host controller and flash
interface flash_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;

	modport host (output sclk, output cs_n, output mosi, input miso);
	modport flash (input sclk, input cs_n, input mosi, output miso);
endinterface

// ==== design/bit_sync.sv ====
`timescale 1ns/1ps
// =====================================================================
// Two flip-flop synchroniser, one per bit, bits independent
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Destination clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_reg <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule

// ==== design/flash_status_regs.sv ====
`timescale 1ns/1ps
module flash_status_regs #(
	parameter int CNT_W = 12,
	parameter int WRITE_CYCLES = flash_pkg::STATUS_WRITE_CYCLES
) (
	// Reference clock and power-on reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Serial link
	flash_link_if.flash link,
	// Write protect pin and array engine
	input wire logic i_wp_n,
	input wire logic i_array_op_done,
	output logic o_array_op_start,
	output logic [7:0] o_array_opcode,
	// Status and configuration
	output logic o_busy,
	output logic o_write_latch,
	output logic o_paused,
	output logic o_quad_io_enable,
	output logic o_wp_pin_enable,
	output logic o_hold_enable,
	output logic o_reset_pin_enable,
	output logic o_fast_quad_mode,
	output logic [1:0] o_drive_level,
	output logic [5:0] o_array_protect,
	output logic [2:0] o_otp_lock
);
	generate
		if (CNT_W < 6 || WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin : g_bad_param
			$error("flash_status_regs: CNT_W or WRITE_CYCLES out of range");
		end
	endgenerate

	// Merge written data into the bits a mask allows
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// =================================================================
	// Link clock domain: shifter and status read-out
	logic in_frame_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] cmd_reg;
	logic [7:0] data0_reg;
	logic [7:0] data1_reg;
	logic miso_reg;
	logic [23:0] stat_reg;
	logic [23:0] stat_sclk;

	wire logic [7:0] shift_in = {shift_reg[6:0], link.mosi};
	wire logic [CNT_W-1:0] cnt_next = !in_frame_reg ? CNT_W'(1) :
		((&cnt_reg) ? cnt_reg : cnt_reg + CNT_W'(1));

	// Frame flag falls as soon as chip select rises
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	// Bit counter and byte capture; held still once the frame ends
	always_ff @(posedge link.sclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_reg <= '0;
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			data0_reg <= 8'h00;
			data1_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
			shift_reg <= shift_in;
			if (cnt_next == CNT_W'(flash_pkg::LEN_CMD)) cmd_reg <= shift_in;
			if (cnt_next == CNT_W'(flash_pkg::LEN_ONE)) data0_reg <= shift_in;
			if (cnt_next == CNT_W'(flash_pkg::LEN_TWO)) data1_reg <= shift_in;
		end
	end

	// Status bytes brought into the link domain, each bit a slow level
	bit_sync #(.WIDTH(24), .RESET_VAL(24'h000000)) u_stat_sync (
		.i_clk(link.sclk),
		.i_reset_n(i_reset_n),
		.i_async(stat_reg),
		.o_sync(stat_sclk)
	);

	// Read selection; reads are served even while busy
	wire logic [7:0] rd_byte = (cmd_reg == flash_pkg::OP_READ_BYTE_ONE) ? stat_sclk[7:0] :
		(cmd_reg == flash_pkg::OP_READ_BYTE_TWO) ? stat_sclk[15:8] :
		(cmd_reg == flash_pkg::OP_READ_BYTE_THREE) ? stat_sclk[23:16] : 8'h00;
	wire logic rd_active = in_frame_reg && (cnt_reg >= CNT_W'(flash_pkg::LEN_CMD));
	wire logic [2:0] rd_idx = 3'(flash_pkg::BYTE_BITS - 1) - cnt_reg[2:0];

	// Data out changes on the falling edge, most significant bit first
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			miso_reg <= 1'b0;
		end else begin
			miso_reg <= rd_active & rd_byte[rd_idx];
		end
	end
	assign link.miso = miso_reg;

	// =================================================================
	// Reference clock domain: decode and registers
	flash_pkg::dev_state_t state_reg;
	logic [15:0] busy_cnt_reg;
	logic [1:0] pin_ref;
	logic cs_last_reg;
	logic latch_reg;
	logic vol_sel_reg;
	logic paused_reg;
	logic armed_reg;
	logic [7:0] nv1_reg, nv2_reg, nv3_reg;
	logic [7:0] vol1_reg, vol2_reg, vol3_reg;

	// Chip select and protect pin synchronised
	bit_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_pin_sync (
		.i_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_async({link.cs_n, i_wp_n}),
		.o_sync(pin_ref)
	);

	// Frame end; captured link bytes are static while chip select is high
	wire logic cs_rise = pin_ref[1] & ~cs_last_reg;
	wire logic idle = state_reg == flash_pkg::DEV_IDLE;
	wire logic on_byte = cnt_reg[2:0] == 3'h0;
	wire logic take = cs_rise & idle & on_byte;
	wire logic len_cmd = cnt_reg == CNT_W'(flash_pkg::LEN_CMD);
	wire logic len_one = cnt_reg == CNT_W'(flash_pkg::LEN_ONE);
	wire logic len_two = cnt_reg == CNT_W'(flash_pkg::LEN_TWO);
	wire logic single = take & len_cmd;
	wire logic op_is_wren = cmd_reg == flash_pkg::OP_WRITE_ENABLE;
	wire logic op_is_w1 = cmd_reg == flash_pkg::OP_WRITE_BYTE_ONE;
	wire logic op_is_w2 = cmd_reg == flash_pkg::OP_WRITE_BYTE_TWO;
	wire logic op_is_w3 = cmd_reg == flash_pkg::OP_WRITE_BYTE_THREE;
	wire logic cmd_wren = single & op_is_wren;
	wire logic cmd_wrdi = single & (cmd_reg == flash_pkg::OP_WRITE_DISABLE);
	wire logic cmd_vwren = single & (cmd_reg == flash_pkg::OP_VOL_WRITE_ENABLE);
	wire logic cmd_suspend = single & (cmd_reg == flash_pkg::OP_SUSPEND);
	wire logic cmd_resume = single & (cmd_reg == flash_pkg::OP_RESUME);
	wire logic cmd_arm = single & (cmd_reg == flash_pkg::OP_RESET_ARM);
	wire logic do_reset = single & (cmd_reg == flash_pkg::OP_RESET) & armed_reg;

	// Protect mode from the volatile copies; pin counts only without quad
	wire logic [1:0] mode = {vol2_reg[flash_pkg::B2_PROT_UPPER], vol1_reg[flash_pkg::B1_PROT_LOWER]};
	wire logic quad = vol2_reg[flash_pkg::B2_QUAD];
	wire logic wp_low = ~pin_ref[0] & ~quad;
	wire logic locked = (mode == flash_pkg::PROT_LOCKDOWN)
		| (mode == flash_pkg::PROT_OTP)
		| ((mode == flash_pkg::PROT_PIN) & wp_low);

	// Status writes; a locked or unenabled write is dropped whole
	wire logic wr_shape = (op_is_w1 & (len_one | len_two)) | ((op_is_w2 | op_is_w3) & len_one);
	wire logic wr_go = take & wr_shape & (latch_reg | vol_sel_reg) & ~locked;
	wire logic nv_go = wr_go & ~vol_sel_reg;
	wire logic wr_one = wr_go & op_is_w1;
	wire logic wr_two = wr_go & ((op_is_w1 & len_two) | op_is_w2);
	wire logic wr_three = wr_go & op_is_w3;
	wire logic [7:0] two_data = op_is_w2 ? data0_reg : data1_reg;

	// Program and erase hand-off, only with the latch set
	wire logic arr_shape = ((cmd_reg == flash_pkg::OP_PAGE_PROGRAM)
		& (cnt_reg >= CNT_W'(flash_pkg::LEN_PROGRAM_MIN)))
		| (((cmd_reg == flash_pkg::OP_SECTOR_ERASE) | (cmd_reg == flash_pkg::OP_BLOCK_ERASE))
		& (cnt_reg == CNT_W'(flash_pkg::LEN_ERASE)))
		| ((cmd_reg == flash_pkg::OP_CHIP_ERASE) & len_cmd);
	wire logic arr_go = take & arr_shape & latch_reg;
	wire logic op_done = ((state_reg == flash_pkg::DEV_STATUS_WRITE) & (busy_cnt_reg == 16'h0000))
		| ((state_reg == flash_pkg::DEV_ARRAY_OP) & i_array_op_done);

	// Flag next values; one command per frame, so set and clear never meet
	wire logic latch_next = cmd_wren ? 1'b1 :
		(cmd_wrdi | op_done | do_reset) ? 1'b0 : latch_reg;
	wire logic vol_sel_next = cmd_vwren ? 1'b1 :
		(cmd_wren | cmd_wrdi | (wr_go & vol_sel_reg) | do_reset) ? 1'b0 : vol_sel_reg;
	wire logic paused_next = cmd_suspend ? 1'b1 :
		(cmd_resume | do_reset) ? 1'b0 : paused_reg;

	// Lockdown clears on software reset before the reload
	wire logic nv_lockdown = {nv2_reg[flash_pkg::B2_PROT_UPPER], nv1_reg[flash_pkg::B1_PROT_LOWER]}
		== flash_pkg::PROT_LOCKDOWN;
	wire logic [7:0] nv2_fixed = nv_lockdown ? (nv2_reg & ~flash_pkg::PROT_UPPER_MASK) : nv2_reg;

	// Register next values; lock bits only ever set, never by volatile writes
	wire logic [7:0] nv1_next = (nv_go & wr_one) ?
		merge(nv1_reg, data0_reg, flash_pkg::CFG_MASK_ONE) : nv1_reg;
	wire logic [7:0] nv2_next = (nv_go & wr_two) ?
		(merge(nv2_reg, two_data, flash_pkg::CFG_MASK_TWO)
		| (two_data & flash_pkg::LOCK_MASK_TWO)) : (do_reset ? nv2_fixed : nv2_reg);
	wire logic [7:0] nv3_next = (nv_go & wr_three) ?
		merge(nv3_reg, data0_reg, flash_pkg::CFG_MASK_THREE) : nv3_reg;
	wire logic [7:0] vol1_next = do_reset ? nv1_reg :
		(wr_one ? merge(vol1_reg, data0_reg, flash_pkg::CFG_MASK_ONE) : vol1_reg);
	wire logic [7:0] vol2_next = do_reset ? (nv2_fixed & flash_pkg::CFG_MASK_TWO) :
		(wr_two ? merge(vol2_reg, two_data, flash_pkg::CFG_MASK_TWO) : vol2_reg);
	wire logic [7:0] vol3_next = do_reset ? nv3_reg :
		(wr_three ? merge(vol3_reg, data0_reg, flash_pkg::CFG_MASK_THREE) : vol3_reg);

	// Status bytes as read; hardware-owned bits come only from hardware
	wire logic busy = ~idle;
	wire logic [7:0] stat_one = (vol1_reg & flash_pkg::CFG_MASK_ONE)
		| (latch_reg ? flash_pkg::LATCH_MASK : 8'h00)
		| (busy ? flash_pkg::BUSY_MASK : 8'h00);
	wire logic [7:0] stat_two = (vol2_reg & flash_pkg::CFG_MASK_TWO)
		| (nv2_reg & flash_pkg::LOCK_MASK_TWO) | (paused_reg ? flash_pkg::PAUSED_MASK : 8'h00);
	wire logic [7:0] stat_three = vol3_reg & flash_pkg::CFG_MASK_THREE;

	// Command flags
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_last_reg <= 1'b1;
			latch_reg <= 1'b0;
			vol_sel_reg <= 1'b0;
			paused_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			cs_last_reg <= pin_ref[1];
			latch_reg <= latch_next;
			vol_sel_reg <= vol_sel_next;
			paused_reg <= paused_next;
			if (take) armed_reg <= cmd_arm;
		end
	end

	// Busy sequencer
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= flash_pkg::DEV_IDLE;
			busy_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				flash_pkg::DEV_IDLE: begin
					busy_cnt_reg <= 16'(WRITE_CYCLES - 1);
					if (nv_go) state_reg <= flash_pkg::DEV_STATUS_WRITE;
					else if (arr_go) state_reg <= flash_pkg::DEV_ARRAY_OP;
				end
				flash_pkg::DEV_STATUS_WRITE: begin
					busy_cnt_reg <= busy_cnt_reg - 16'h0001;
					if (op_done) state_reg <= flash_pkg::DEV_IDLE;
				end
				flash_pkg::DEV_ARRAY_OP: begin
					if (op_done) state_reg <= flash_pkg::DEV_IDLE;
				end
				default: state_reg <= flash_pkg::DEV_IDLE;
			endcase
		end
	end

	// Status and configuration storage; power-up loads factory values
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			nv1_reg <= flash_pkg::NV_ONE_RESET;
			nv2_reg <= flash_pkg::NV_TWO_RESET;
			nv3_reg <= flash_pkg::NV_THREE_RESET;
			vol1_reg <= flash_pkg::NV_ONE_RESET & flash_pkg::CFG_MASK_ONE;
			vol2_reg <= flash_pkg::NV_TWO_RESET & flash_pkg::CFG_MASK_TWO;
			vol3_reg <= flash_pkg::NV_THREE_RESET & flash_pkg::CFG_MASK_THREE;
		end else begin
			nv1_reg <= nv1_next;
			nv2_reg <= nv2_next;
			nv3_reg <= nv3_next;
			vol1_reg <= vol1_next;
			vol2_reg <= vol2_next;
			vol3_reg <= vol3_next;
		end
	end

	// Registered outputs and status image for the link domain
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stat_reg <= 24'h000000;
			o_array_op_start <= 1'b0;
			o_array_opcode <= 8'h00;
			o_busy <= 1'b0;
			o_write_latch <= 1'b0;
			o_paused <= 1'b0;
			o_quad_io_enable <= 1'b0;
			o_wp_pin_enable <= 1'b1;
			o_hold_enable <= 1'b1;
			o_reset_pin_enable <= 1'b0;
			o_fast_quad_mode <= 1'b0;
			o_drive_level <= 2'h0;
			o_array_protect <= 6'h00;
			o_otp_lock <= 3'h0;
		end else begin
			stat_reg <= {stat_three, stat_two, stat_one};
			o_array_op_start <= arr_go & idle;
			if (arr_go) o_array_opcode <= cmd_reg;
			o_busy <= busy;
			o_write_latch <= latch_reg;
			o_paused <= paused_reg;
			o_quad_io_enable <= quad;
			o_wp_pin_enable <= ~quad;
			o_hold_enable <= ~quad & ~vol3_reg[flash_pkg::B3_SHARED_PIN];
			o_reset_pin_enable <= ~quad & vol3_reg[flash_pkg::B3_SHARED_PIN];
			o_fast_quad_mode <= vol3_reg[flash_pkg::B3_FAST_QUAD];
			o_drive_level <= vol3_reg[flash_pkg::B3_DRIVE_LSB +: 2];
			o_array_protect <= {vol2_reg[flash_pkg::B2_INVERT],
				vol1_reg[flash_pkg::B1_RANGE_LSB +: 5]};
			o_otp_lock <= nv2_reg[flash_pkg::B2_LOCK_LSB +: 3];
		end
	end
endmodule

// ==== design/flash_link_host.sv ====
`timescale 1ns/1ps
// =====================================================================
// Host end: sends one instruction frame per request, returns last byte
module flash_link_host #(
	parameter int DIV_HALF = 4,
	parameter int CS_GAP = 8
) (
	// Reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Serial link
	flash_link_if.host link,
	// Request
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_opcode,
	input wire logic [1:0] i_cmd_bytes,
	input wire logic [23:0] i_cmd_data,
	output logic o_cmd_ready,
	// Answer
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data
);
	generate
		if (DIV_HALF < 3 || DIV_HALF > 255 || CS_GAP < 4 || CS_GAP > 255) begin : g_bad_param
			$error("flash_link_host: DIV_HALF needs 3..255, CS_GAP needs 4..255");
		end
	endgenerate

	flash_pkg::host_state_t state_reg;
	logic [7:0] div_reg;
	logic [31:0] tx_reg;
	logic [5:0] bits_reg;
	logic [7:0] rx_reg;
	logic sclk_reg, cs_n_reg, mosi_reg;
	logic miso_s;

	// Data in from the flash passes two flops
	bit_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_miso_sync (
		.i_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_async(link.miso),
		.o_sync(miso_s)
	);

	// Half-period and gap timing
	wire logic half_done = div_reg == 8'(DIV_HALF - 1);
	wire logic gap_done = div_reg == 8'(CS_GAP - 1);
	wire logic [5:0] frame_bits = 6'(flash_pkg::BYTE_BITS) * ({4'h0, i_cmd_bytes} + 6'h01);
	wire logic start = i_cmd_valid & o_cmd_ready;

	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.mosi = mosi_reg;

	// Frame sequencer, mode zero: data set while clock low, taken on rise
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= flash_pkg::HOST_IDLE;
			div_reg <= 8'h00;
			tx_reg <= 32'h00000000;
			bits_reg <= 6'h00;
			rx_reg <= 8'h00;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
			o_cmd_ready <= 1'b1;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 8'h00;
		end else begin
			o_rsp_valid <= 1'b0;
			div_reg <= (state_reg == flash_pkg::HOST_IDLE || half_done && state_reg
				!= flash_pkg::HOST_GAP) ? 8'h00 : div_reg + 8'h01;
			case (state_reg)
				flash_pkg::HOST_IDLE: begin
					if (start) begin
						tx_reg <= {i_cmd_opcode, i_cmd_data};
						bits_reg <= frame_bits;
						cs_n_reg <= 1'b0;
						mosi_reg <= i_cmd_opcode[7];
						o_cmd_ready <= 1'b0;
						state_reg <= flash_pkg::HOST_RISE_WAIT;
					end
				end
				flash_pkg::HOST_RISE_WAIT: begin
					if (half_done) begin
						sclk_reg <= 1'b1;
						rx_reg <= {rx_reg[6:0], miso_s};
						bits_reg <= bits_reg - 6'h01;
						state_reg <= flash_pkg::HOST_FALL_WAIT;
					end
				end
				flash_pkg::HOST_FALL_WAIT: begin
					if (half_done) begin
						sclk_reg <= 1'b0;
						tx_reg <= {tx_reg[30:0], 1'b0};
						mosi_reg <= tx_reg[30];
						state_reg <= (bits_reg == 6'h00) ? flash_pkg::HOST_TAIL :
							flash_pkg::HOST_RISE_WAIT;
					end
				end
				flash_pkg::HOST_TAIL: begin
					if (half_done) begin
						cs_n_reg <= 1'b1;
						mosi_reg <= 1'b0;
						state_reg <= flash_pkg::HOST_GAP;
					end
				end
				flash_pkg::HOST_GAP: begin
					// Chip select stays high long enough for the flash to decode
					if (gap_done) begin
						o_rsp_valid <= 1'b1;
						o_rsp_data <= rx_reg;
						o_cmd_ready <= 1'b1;
						state_reg <= flash_pkg::HOST_IDLE;
					end
				end
				default: state_reg <= flash_pkg::HOST_IDLE;
			endcase
		end
	end
endmodule

// ==== dv/flash_status_protect_regs_asserts.sv ====
`timescale 1ns/1ps
// =========================================
// Status flag checks beside the link
module flash_status_protect_regs_asserts (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Link and device flags
	input wire logic cs_n,
	input wire logic o_busy,
	input wire logic o_write_latch,
	input wire logic o_paused,
	input wire logic o_quad_io_enable,
	input wire logic o_wp_pin_enable,
	input wire logic o_hold_enable,
	input wire logic o_reset_pin_enable
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// Busy phase: start, then hold
	sequence s_go; $rose(o_busy); endsequence
	sequence s_hold; o_busy [*8]; endsequence
	property p_busy_hold; s_go |-> s_hold; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy short");
	property p_busy_end; s_go |-> ##[1:1000] !o_busy; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy stuck");
	property p_quiet; o_busy |-> !$rose(o_write_latch); endproperty
	a_quiet: assert property (p_quiet) else $error("latch set in busy");
	property p_drop; $fell(o_busy) |-> ##[0:2] !o_write_latch; endproperty
	a_drop: assert property (p_drop) else $error("latch kept");
	property p_rise; $rose(o_write_latch) |-> cs_n && $past(cs_n, 3); endproperty
	a_rise: assert property (p_rise) else $error("latch mid frame");
	property p_pause; $rose(o_paused) |-> !o_busy; endproperty
	a_pause: assert property (p_pause) else $error("pause in busy");
	property p_keep; o_busy && $past(o_busy) |-> $stable(o_paused); endproperty
	a_keep: assert property (p_keep) else $error("pause moved");
	property p_quad; o_quad_io_enable |-> !(o_wp_pin_enable | o_hold_enable); endproperty
	a_quad: assert property (p_quad) else $error("pin ctrl in quad");
	property p_pick; !o_quad_io_enable |-> o_hold_enable != o_reset_pin_enable; endproperty
	a_pick: assert property (p_pick) else $error("shared pin");
endmodule

// ==== dv/flash_status_protect_regs_bench.sv ====
`timescale 1ns/1ps
// =========================================
// Host end drives device end over the link
module flash_status_protect_regs_bench;
	logic i_ref_clk = 0;
	logic i_reset_n = 0;
	logic i_wp_n = 1;
	logic done = 0;
	logic vld = 0;
	logic [7:0] op = 0, rd, rsp, aop, b1, b2, b3;
	logic [1:0] nb = 0, drv;
	logic [23:0] dat = 0;
	logic rdy, rv, st, busy, wl, pa, qe, wpe, hoe, rpe, fq;
	logic [5:0] ap;
	logic [2:0] otp;
	int err_count = 0;
	int samples_checked = 0;
	int starts = 0;
	flash_link_if link_if ();
	flash_status_regs flash_status_regs_inst (.i_ref_clk, .i_reset_n, .link(link_if.flash),
		.i_wp_n, .i_array_op_done(done), .o_array_op_start(st), .o_array_opcode(aop),
		.o_busy(busy), .o_write_latch(wl), .o_paused(pa), .o_quad_io_enable(qe),
		.o_wp_pin_enable(wpe), .o_hold_enable(hoe), .o_reset_pin_enable(rpe),
		.o_fast_quad_mode(fq), .o_drive_level(drv), .o_array_protect(ap), .o_otp_lock(otp));
	flash_link_host flash_link_host_inst (.i_ref_clk, .i_reset_n, .link(link_if.host),
		.i_cmd_valid(vld), .i_cmd_opcode(op), .i_cmd_bytes(nb), .i_cmd_data(dat),
		.o_cmd_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rsp));
	flash_status_protect_regs_asserts flash_status_protect_regs_asserts_inst (.i_ref_clk,
		.i_reset_n, .cs_n(link_if.cs_n), .o_busy(busy), .o_write_latch(wl), .o_paused(pa),
		.o_quad_io_enable(qe), .o_wp_pin_enable(wpe), .o_hold_enable(hoe),
		.o_reset_pin_enable(rpe));
	// Reference clock
	initial forever #25 i_ref_clk = ~i_ref_clk;
	// Count array start pulses away from the launching edge
	always @(negedge i_ref_clk) if (st === 1'b1) starts++;
	// Expected read view of a written byte
	function automatic logic [7:0] seen(input logic [7:0] d, input logic [7:0] m);
		return d & m;
	endfunction
	// One frame; answer kept, ends two edges after it
	task automatic xfer(input logic [7:0] o, input logic [1:0] n, input logic [23:0] d);
		@(posedge i_ref_clk) #2;
		op = o;
		nb = n;
		dat = d;
		vld = 1;
		@(posedge i_ref_clk) #2 vld = 0;
		for (int k = 0; k < 400 && rv !== 1'b1; k++) @(posedge i_ref_clk) #1;
		if (rv !== 1'b1) begin
			err_count++;
			$display("wrong value answer exp 1 got %b", rv);
		end
		rd = rsp;
		repeat (2) @(posedge i_ref_clk);
		#2;
	endtask
	// Enable frame then command
	task automatic wr(input logic [7:0] e, o, input logic [1:0] n, input logic [23:0] d);
		xfer(e, 0, 0);
		xfer(o, n, d);
	endtask
	// Compare one value
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	// Read a status byte and compare
	task automatic rdchk(input logic [7:0] o, input logic [7:0] e);
		xfer(o, 1, 0);
		chk("status", e, rd);
	endtask
	// Counts and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(80000 * 50);
		err_count++;
		print_verdict();
	end
	// Tests
	initial begin
		b1 = 8'($urandom(43));
		repeat (16) @(posedge i_ref_clk);
		#2 i_reset_n = 1;
		rdchk(8'h05, 8'h00);
		rdchk(8'h35, 8'h00);
		rdchk(8'h15, 8'h00);
		chk("pins", 8'h06, 8'({qe, wpe, hoe, rpe}));
		xfer(8'h01, 2, 24'h1C0000);
		rdchk(8'h05, 8'h00);
		$display("test defaults done");
		for (int i = 0; i < 6; i++) begin
			b1 = 8'($urandom) & 8'h7F;
			b2 = 8'($urandom) & 8'hC2;
			b3 = 8'($urandom);
			i_wp_n = 1'($urandom);
			wr(8'h06, 8'h01, 2, {b1, b2, 8'h00});
			chk("busy", 8'h01, 8'(busy));
			wr(8'h06, 8'h11, 1, {b3, 16'h0000});
			rdchk(8'h05, seen(b1, flash_pkg::CFG_MASK_ONE));
			rdchk(8'h35, seen(b2, flash_pkg::CFG_MASK_TWO));
			rdchk(8'h15, seen(b3, flash_pkg::CFG_MASK_THREE));
			chk("protect", 8'({b2[6], b1[6:2]}), 8'(ap));
			chk("pins", 8'({b2[1], !b2[1], !(b2[1] | b3[7]), !b2[1] & b3[7]}),
				8'({qe, wpe, hoe, rpe}));
			chk("drive", 8'({b3[4], b3[6:5]}), 8'({fq, drv}));
		end
		$display("test random writes done");
		wr(8'h50, 8'h01, 2, 24'h1C7800);
		chk("busy", 8'h00, 8'(busy));
		rdchk(8'h05, 8'h1C);
		rdchk(8'h35, 8'h40);
		wr(8'h66, 8'h99, 0, 0);
		rdchk(8'h05, seen(b1, flash_pkg::CFG_MASK_ONE));
		wr(8'h06, 8'h31, 1, 24'h080000);
		chk("lock", 8'h01, 8'(otp));
		$display("test volatile done");
		i_wp_n = 1;
		wr(8'h06, 8'h01, 2, 24'h800000);
		i_wp_n = 0;
		wr(8'h06, 8'h01, 2, 24'h9C0000);
		rdchk(8'h05, 8'h82);
		i_wp_n = 1;
		wr(8'h06, 8'h01, 2, 24'h840000);
		rdchk(8'h05, 8'h84);
		wr(8'h06, 8'h01, 2, 24'h000100);
		wr(8'h06, 8'h01, 2, 24'h1C0000);
		rdchk(8'h05, 8'h02);
		wr(8'h66, 8'h99, 0, 0);
		rdchk(8'h35, 8'h08);
		wr(8'h06, 8'h01, 2, 24'h800100);
		wr(8'h06, 8'h01, 2, 24'h000000);
		rdchk(8'h05, 8'h82);
		$display("test protect modes done");
		xfer(8'h75, 0, 0);
		chk("paused", 8'h01, 8'(pa));
		rdchk(8'h35, 8'h89);
		xfer(8'h7A, 0, 0);
		chk("paused", 8'h00, 8'(pa));
		wr(8'h06, 8'h20, 3, 24'h010000);
		chk("opcode", 8'h20, aop);
		chk("start", 8'h01, 8'(starts));
		xfer(8'h75, 0, 0);
		rdchk(8'h05, 8'h83);
		chk("paused", 8'h00, 8'(pa));
		done = 1;
		@(posedge i_ref_clk) #2 done = 0;
		rdchk(8'h05, 8'h80);
		xfer(8'h06, 0, 0);
		chk("latch", 8'h01, 8'(wl));
		xfer(8'h04, 0, 0);
		rdchk(8'h05, 8'h80);
		$display("test suspend and erase done");
		xfer(8'h75, 0, 0);
		i_reset_n = 0;
		repeat (2) @(posedge i_ref_clk);
		#2 i_reset_n = 1;
		chk("paused", 8'h00, 8'(pa));
		rdchk(8'h35, 8'h00);
		$display("test power cycle done");
		print_verdict();
	end
endmodule
